// file: cph_coproc_model.sv
`timescale 1ns/1ps
module cph_coproc_model (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        clk_en,
   input wire logic        strobe_low,
   input wire logic        respond,
   input wire logic        incap,
   input wire logic [3:0]  wait_cyc,
   input wire logic [31:0] word,
   output logic            absent,
   output logic            busy,
   output logic [31:0]     data
);
   logic [3:0] cnt_q;
   logic       started_q;
   logic       done_q;
   wire  [3:0] rem = started_q ? cnt_q : wait_cyc;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q     <= 4'h0;
         started_q <= 1'b0;
         done_q    <= 1'b0;
      end else if (!respond) begin
         cnt_q     <= 4'h0;
         started_q <= 1'b0;
         done_q    <= 1'b0;
      end else if (clk_en) begin
         started_q <= 1'b1;
         if (rem == 4'h0) begin
            done_q <= 1'b1;
         end else if (!started_q || !strobe_low) begin
            cnt_q <= rem - 4'h1;
         end
      end
   end
   // incapable or finished: both lines stay high
   assign absent = incap | !respond | done_q;
   assign busy   = absent | (rem != 4'h0);
   assign data   = respond ? word : ~word;
endmodule // cph_coproc_model

// file: cph_core.sv
`timescale 1ns/1ps
`include "cph_defines.svh"
// Functional notes
// (RULE_01) load from coprocessor writes one word, cycle three
// (RULE_02) third cycle merges with next fetch
// (RULE_03) store drives register, write high, no third
// (RULE_04) incapable coprocessor leaves both lines high
// (RULE_05) both lines high takes undefined trap
// (RULE_06) failed condition costs one sequential cycle
// (RULE_07) multiply cycles from operand, 1 to 16
// (RULE_08) each busy-wait cycle adds one internal
// (RULE_09) fetch, decode, execute run overlapped
// (RULE_10) absent low, busy high means busy-wait
// (RULE_11) transfer cycle: no request, fetch address; the store (MCR) transfer cycle here keeps memory_request_low low

module cph_core
   import cph_pkg::*;
#(
   parameter int WORD_W = `CPH_WORD_W
) (
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   input  wire logic              instr_valid,
   input  wire logic [`CPH_OP_W-1:0] instr_op,
   input  wire logic              instr_cond_pass,
   input  wire logic [WORD_W-1:0] mul_operand,
   input  wire logic [WORD_W-1:0] store_reg_value,
   input  wire logic [WORD_W-1:0] data_in,
   input  wire logic              coproc_absent_line,
   input  wire logic              coproc_busy_line,
   output logic      [WORD_W-1:0] address,
   output logic      [WORD_W-1:0] data_out,
   output logic                   data_out_en,
   output logic                   memory_request_low,
   output logic                   sequential_access,
   output logic                   write_not_read,
   output logic                   word_not_byte,
   output logic                   opcode_fetch_low,
   output logic                   coproc_instruction_strobe_low,
   output logic                   instr_accept,
   output logic      [WORD_W-1:0] dest_reg_value,
   output logic                   dest_reg_write,
   output logic                   undef_trap,
   output logic      [`CPH_CNT_W-1:0] s_cycles,
   output logic      [`CPH_CNT_W-1:0] n_cycles,
   output logic      [`CPH_CNT_W-1:0] i_cycles,
   output logic      [`CPH_CNT_W-1:0] c_cycles
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   cph_state_t                state_q, state_d;
   logic [WORD_W-1:0]         pc_q;
   logic [`CPH_OP_W-1:0]      op_q;
   logic [`CPH_MUL_W-1:0]     mul_left_q;
   logic [`CPH_MUL_W-1:0]     mul_need;
   logic [WORD_W-1:0]         cp_word_q;
   logic [`CPH_CNT_W-1:0]     s_q, n_q, i_q, c_q;

   cph_mul_count #(.WORD_W(WORD_W)) u_mul (
      .multiplier (mul_operand),
      .icycles    (mul_need)
   );

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire in_fetch  = (state_q == CPH_ST_FETCH);
   wire take      = in_fetch && instr_valid;
   wire cond_fail = take && !instr_cond_pass;
   wire is_cp     = (instr_op == `CPH_OP_CDP) || (instr_op == `CPH_OP_MRC)
                    || (instr_op == `CPH_OP_MCR);
   wire start_cp  = take && instr_cond_pass && is_cp;
   wire start_mul = take && instr_cond_pass && (instr_op == `CPH_OP_MUL);
   wire in_cp     = start_cp || (state_q == CPH_ST_CP_WAIT);
   wire cp_ready  = !coproc_absent_line && !coproc_busy_line;
   wire cp_busy   = !coproc_absent_line && coproc_busy_line; // [RULE_10]
   wire cp_none   = coproc_absent_line && coproc_busy_line; // [RULE_04]
   wire cur_op_mrc = start_cp ? (instr_op == `CPH_OP_MRC)
                              : (op_q == `CPH_OP_MRC);
   wire cur_op_mcr = start_cp ? (instr_op == `CPH_OP_MCR)
                              : (op_q == `CPH_OP_MCR);
   wire [WORD_W-1:0] pc_next = pc_q + `CPH_PC_STEP;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         CPH_ST_FETCH: begin
            if (start_mul && mul_need != `CPH_MUL_W'(0)) begin
               state_d = CPH_ST_MUL; // [RULE_07]
            end else if (start_cp) begin
               if (cp_none) begin
                  state_d = CPH_ST_UNDEF; // [RULE_05]
               end else if (cp_ready) begin
                  state_d = (instr_op == `CPH_OP_CDP) ? CPH_ST_FETCH
                                                      : CPH_ST_CP_XFER;
               end else begin
                  state_d = CPH_ST_CP_WAIT;
               end
            end
         end
         CPH_ST_MUL: begin
            if (mul_left_q == `CPH_MUL_W'(1)) begin
               state_d = CPH_ST_FETCH;
            end
         end
         CPH_ST_CP_WAIT: begin
            if (cp_none) begin
               state_d = CPH_ST_UNDEF; // [RULE_05]
            end else if (cp_ready) begin
               state_d = (op_q == `CPH_OP_CDP) ? CPH_ST_FETCH
                                               : CPH_ST_CP_XFER;
            end
         end
         CPH_ST_CP_XFER: begin
            state_d = (op_q == `CPH_OP_MRC) ? CPH_ST_CP_WB
                                            : CPH_ST_FETCH; // [RULE_03]
         end
         CPH_ST_CP_WB: state_d = CPH_ST_FETCH; // [RULE_02]
         CPH_ST_UNDEF: state_d = CPH_ST_FETCH;
         default: state_d = CPH_ST_FETCH;
      endcase
   end

   // ---------------------------------------------------------------
   // bus pin values per state
   // ---------------------------------------------------------------
   wire xfer = (state_q == CPH_ST_CP_XFER);
   wire wb   = (state_q == CPH_ST_CP_WB);
   wire und  = (state_q == CPH_ST_UNDEF);
   wire mreq_low_d = (in_cp && !(cp_ready && !cur_op_mrc && !cur_op_mcr))
                     || (xfer && op_q == `CPH_OP_MRC)
                     || (state_q == CPH_ST_MUL); // [RULE_11]
   wire seq_d   = cond_fail || (in_cp && cp_ready
                  && (cur_op_mrc || cur_op_mcr)) || wb; // [RULE_06]
   wire wr_d    = xfer && (op_q == `CPH_OP_MCR); // [RULE_03]
   wire cpi_d   = !in_cp;
   wire opc_d   = !(take || und);
   wire [WORD_W-1:0] addr_d = und ? `CPH_UNDEF_VECTOR
                             : (xfer || wb) ? pc_next : pc_q; // [RULE_11]

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q    <= CPH_ST_FETCH;
         pc_q       <= `CPH_PC_RESET;
         op_q       <= `CPH_OP_PLAIN;
         mul_left_q <= '0;
         cp_word_q  <= '0;
      end else if (clk_en) begin
         state_q <= state_d;
         if (take) begin
            op_q <= instr_op;
         end
         if (start_mul) begin
            mul_left_q <= mul_need;
         end else if (state_q == CPH_ST_MUL) begin
            mul_left_q <= mul_left_q - `CPH_MUL_W'(1);
         end
         if (xfer && op_q == `CPH_OP_MRC) begin
            cp_word_q <= data_in; // [RULE_01]
         end
         if (und) begin
            pc_q <= `CPH_UNDEF_VECTOR; // [RULE_05]
         end else if (take && state_d == CPH_ST_FETCH) begin
            pc_q <= pc_next; // [RULE_09]
         end else if (state_q != CPH_ST_FETCH
                      && state_d == CPH_ST_FETCH) begin
            pc_q <= pc_next;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         address            <= `CPH_PC_RESET;
         data_out           <= '0;
         data_out_en        <= 1'b0;
         memory_request_low <= 1'b1;
         sequential_access  <= 1'b0;
         write_not_read     <= 1'b0;
         word_not_byte      <= 1'b1;
         opcode_fetch_low   <= 1'b1;
         coproc_instruction_strobe_low <= 1'b1;
         instr_accept       <= 1'b0;
         dest_reg_value     <= '0;
         dest_reg_write     <= 1'b0;
         undef_trap         <= 1'b0;
      end else if (clk_en) begin
         address            <= addr_d;
         data_out           <= wr_d ? store_reg_value : '0; // [RULE_03]
         data_out_en        <= wr_d;
         memory_request_low <= mreq_low_d; // [RULE_11]
         sequential_access  <= seq_d;
         write_not_read     <= wr_d;
         word_not_byte      <= 1'b1;
         opcode_fetch_low   <= opc_d;
         coproc_instruction_strobe_low <= cpi_d;
         instr_accept       <= take;
         dest_reg_value     <= wb ? cp_word_q : dest_reg_value;
         dest_reg_write     <= wb; // [RULE_01]
         undef_trap         <= in_cp && cp_none; // [RULE_05]
      end
   end

   // ---------------------------------------------------------------
   // incremental cycle accounting
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         n_q <= '0;
         i_q <= '0;
         c_q <= '0;
      end else if (clk_en) begin
         if (take) begin
            s_q <= s_q + `CPH_CNT_W'(1); // [RULE_06]
         end
         if (state_q == CPH_ST_MUL) begin
            i_q <= i_q + `CPH_CNT_W'(1); // [RULE_07]
         end else if (in_cp && cp_busy) begin
            i_q <= i_q + `CPH_CNT_W'(1); // [RULE_08]
         end else if (wb) begin
            i_q <= i_q + `CPH_CNT_W'(1);
         end
         if (xfer) begin
            c_q <= c_q + `CPH_CNT_W'(1);
         end
         if (und) begin
            n_q <= n_q + `CPH_CNT_W'(1);
         end
      end
   end

   assign s_cycles = s_q;
   assign n_cycles = n_q;
   assign i_cycles = i_q;
   assign c_cycles = c_q;
endmodule // cph_core

// file: cph_core_props.sv
`timescale 1ns/1ps
`include "cph_defines.svh"
module cph_core_props #(
   parameter int WORD_W = 32
) (
   input wire logic              ref_clk,
   input wire logic              sys_rst,
   input wire logic              clk_en,
   input wire logic [WORD_W-1:0] address,
   input wire logic              data_out_en,
   input wire logic              memory_request_low,
   input wire logic              sequential_access,
   input wire logic              write_not_read,
   input wire logic              word_not_byte,
   input wire logic              dest_reg_write,
   input wire logic              undef_trap
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_word_fixed: assert property (word_not_byte)
      else $error("byte access seen");
   a_store_write: assert property (data_out_en |-> write_not_read)
      else $error("store word without write");
   a_store_req: assert property (data_out_en |-> !memory_request_low)
      else $error("store word without request");
   a_load_merge: assert property ($rose(dest_reg_write) |->
      !memory_request_low && sequential_access)
      else $error("load write not merged with fetch");
   a_load_noreq: assert property ($rose(dest_reg_write) |->
      $past(memory_request_low))
      else $error("request during load transfer");
   a_write_once: assert property (dest_reg_write && clk_en |=>
      !dest_reg_write)
      else $error("more than one load word");
   a_trap_vector: assert property (undef_trap && clk_en |=>
      address == `CPH_UNDEF_VECTOR)
      else $error("trap vector not fetched");
   a_trap_nowrite: assert property (undef_trap |-> !dest_reg_write)
      else $error("trap wrote register");
   a_frozen_addr: assert property (!clk_en |=> $stable(address))
      else $error("address moved while frozen");
   c_load: cover property (dest_reg_write);
   c_store: cover property (data_out_en);
   c_trap: cover property (undef_trap);
endmodule // cph_core_props

// file: cph_defines.svh
`ifndef CPH_DEFINES_SVH
`define CPH_DEFINES_SVH

// ---------------------------------------------------------------
// widths and step sizes
// ---------------------------------------------------------------
`define CPH_WORD_W        32
`define CPH_PC_STEP       32'h0000_0004
`define CPH_PC_RESET      32'h0000_0000
`define CPH_UNDEF_VECTOR  32'h0000_0004

// ---------------------------------------------------------------
// multiply cycle limits
// ---------------------------------------------------------------
`define CPH_MUL_MIN_I     5'h01
`define CPH_MUL_MAX_I     5'h10
`define CPH_MUL_W         5

// ---------------------------------------------------------------
// operation codes
// ---------------------------------------------------------------
`define CPH_OP_W          3
`define CPH_OP_PLAIN      3'h0
`define CPH_OP_MUL        3'h1
`define CPH_OP_CDP        3'h2
`define CPH_OP_MRC        3'h3
`define CPH_OP_MCR        3'h4

`define CPH_CNT_W         16

`endif

// file: cph_mul_count.sv
`timescale 1ns/1ps
`include "cph_defines.svh"

module cph_mul_count
   import cph_pkg::*;
#(
   parameter int WORD_W = `CPH_WORD_W
) (
   input  wire logic [WORD_W-1:0]    multiplier,
   output logic      [`CPH_MUL_W-1:0] icycles
);
   // ---------------------------------------------------------------
   // internal cycles from multiplier magnitude, two bits per cycle
   // ---------------------------------------------------------------
   always_comb begin
      icycles = `CPH_MUL_MIN_I;
      for (int k = 1; k < 16; k++) begin
         if (multiplier[WORD_W-1:0] >= (32'h0000_0001 << (2*k-1))) begin
            icycles = `CPH_MUL_W'(k + 1); // [RULE_07]
         end
      end
      if (icycles > `CPH_MUL_MAX_I) begin
         icycles = `CPH_MUL_MAX_I; // [RULE_07]
      end
   end
endmodule // cph_mul_count

// file: cph_pkg.sv
package cph_pkg;
   typedef enum logic [2:0] {
      CPH_ST_FETCH,
      CPH_ST_MUL,
      CPH_ST_CP_WAIT,
      CPH_ST_CP_XFER,
      CPH_ST_CP_WB,
      CPH_ST_UNDEF
   } cph_state_t;
endpackage

// file: testbench.sv
`timescale 1ns/1ps
`include "cph_defines.svh"
module testbench;
   import cph_pkg::*;
   logic ref_clk = 0, sys_rst = 1, clk_en = 1, instr_valid = 0, cond = 1;
   logic [2:0]  op = 3'h0;
   logic [31:0] opnd = 0, st_val = 0, cp_word = 0, cp_data, address, d_out;
   logic [31:0] dest;
   logic [3:0]  wcyc = 0;
   logic absent, busy, d_en, mreq_n, seq, wnr, wnb, opc_n, cpi_n, acc, dwr, trap;
   logic respond = 0, incap = 0;
   logic [15:0] s_c, n_c, i_c, c_c, i0, n0, s0, c0;
   logic en_q = 0;
   int error_cnt = 0, total_checks = 0;
   always #20 ref_clk = ~ref_clk;
   always @(negedge ref_clk) clk_en <= ($urandom % 8) != 0;
   always @(posedge ref_clk) en_q <= clk_en;
   cph_core cph_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .instr_valid(instr_valid), .instr_op(op),
      .instr_cond_pass(cond), .mul_operand(opnd), .store_reg_value(st_val),
      .data_in(cp_data), .coproc_absent_line(absent),
      .coproc_busy_line(busy), .address(address), .data_out(d_out),
      .data_out_en(d_en), .memory_request_low(mreq_n),
      .sequential_access(seq), .write_not_read(wnr), .word_not_byte(wnb),
      .opcode_fetch_low(opc_n), .coproc_instruction_strobe_low(cpi_n),
      .instr_accept(acc), .dest_reg_value(dest), .dest_reg_write(dwr),
      .undef_trap(trap), .s_cycles(s_c), .n_cycles(n_c), .i_cycles(i_c),
      .c_cycles(c_c));
   cph_coproc_model cph_coproc_model_inst (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .clk_en(clk_en), .strobe_low(cpi_n),
      .respond(respond), .incap(incap), .wait_cyc(wcyc), .word(cp_word),
      .absent(absent), .busy(busy), .data(cp_data));
   task automatic print_verdict();
      if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // next negedge after an enabled edge at which s is high
   task automatic wait_hi(ref logic s);
      int k;
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (!(en_q && s === 1'b1) && k < 300);
      if (!(en_q && s === 1'b1)) begin
         error_cnt++;
         print_verdict();
      end
   endtask
   function automatic logic [31:0] mul_i(logic [31:0] v);
      int m;
      m = 1;
      for (int b = 1; b < 32; b++) if (v[b]) m = (b + 1) / 2 + 1;
      return (m > 16) ? 16 : m;
   endfunction
   // one instruction, then a plain one to see it finished
   task automatic run(logic [2:0] o, logic c, logic ic, logic [3:0] w);
      @(negedge ref_clk);
      i0 = i_c;
      n0 = n_c;
      s0 = s_c;
      c0 = c_c;
      op = o;
      cond = c;
      incap = ic;
      wcyc = w;
      respond = 1;
      instr_valid = 1;
      if (ic && c) wait_hi(trap);
      else wait_hi(acc);
      instr_valid = 0;
      if (ic && c) begin
         wait_hi(en_q);
         chk("trap_addr", address, `CPH_UNDEF_VECTOR);
      end
      if (c && !ic && o == `CPH_OP_MRC) begin
         wait_hi(dwr);
         chk("load_word", dest, cp_word);
      end
      if (c && !ic && o == `CPH_OP_MCR) begin
         wait_hi(d_en);
         chk("store_word", d_out, st_val);
         chk("store_write", wnr, 1);
      end
      @(negedge ref_clk);
      op = `CPH_OP_PLAIN;
      cond = 1;
      instr_valid = 1;
      wait_hi(acc);
      instr_valid = 0;
      respond = 0;
      if (!c) begin
         chk("fail_in", {i_c - i0, n_c - n0}, 0);
         chk("fail_s", s_c - s0, 2);
      end
      else if (ic) chk("trap_n", n_c - n0, 1);
      else if (o == `CPH_OP_MUL) chk("mul_i", i_c - i0, mul_i(opnd));
      else if (o == `CPH_OP_CDP) chk("busy_i", i_c - i0, w);
      else if (o == `CPH_OP_MRC || o == `CPH_OP_MCR)
         chk("xfer_c", c_c - c0, 1);
   endtask
   logic [31:0] corner [6] = '{0, 1, 2, 8, 32'h2000_0000, 32'hFFFF_FFFF};
   initial begin
      void'($urandom(83137));
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk) sys_rst = 0;
      foreach (corner[k]) begin
         opnd = corner[k];
         run(`CPH_OP_MUL, 1, 0, 0);
      end
      for (int k = 0; k < 40; k++) begin
         opnd = $urandom >> ($urandom % 32);
         cp_word = $urandom;
         st_val = $urandom;
         run(3'($urandom % 5), 1, 0, 4'($urandom % 6));
      end
      for (int o = 0; o < 5; o++) run(3'(o), 0, 0, 0);
      run(`CPH_OP_CDP, 1, 1, 0);
      run(`CPH_OP_MRC, 1, 1, 0);
      run(`CPH_OP_MCR, 0, 1, 0);
      print_verdict();
   end
endmodule // testbench
bind cph_core cph_core_props #(.WORD_W(WORD_W)) cph_core_props_inst (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .address(address), .data_out_en(data_out_en),
   .memory_request_low(memory_request_low),
   .sequential_access(sequential_access), .write_not_read(write_not_read),
   .word_not_byte(word_not_byte), .dest_reg_write(dest_reg_write),
   .undef_trap(undef_trap));
